// file: rtl/limit_alarm_monitor.sv
// Functional notes
// - Eight independent alarm channels, each with its own comparison and settings.
// - Each channel compares against a setpoint-relative or an absolute limit.
// - New event starts switch-on countdown; output stays unchanged meanwhile.
// - Countdown expired with event present forwards event to the output.
// - Leaving alarm region resets countdown; full restart on each re-crossing.
// - Switch-off delay mirrors switch-on delay, restarting on re-crossing.
// - Pulse function clears output after pulse time despite ongoing exceedance.
// - Return to valid range resets the pulse timer.
// - Pulse function overrides the switch-off delay.
// - Suppression off: channel always armed, exceedance starts the switch-on countdown at once.
// - Suppression on: output held inactive until valid range first reached.
// - Suppression on: setpoint change or power-up disarms the channel again.
// - Lock off: output clears when event ends, after any delay.
// - Lock on: output latched active until acknowledged.
// - Normal lock: acknowledge accepted only when event no longer present.
// - Always-acknowledgeable lock: any acknowledge clears the latched output.
module limit_alarm_monitor #(
	parameter int TICK_DIV_DEFAULT = limit_alarm_pkg::TICK_CYCLES
) (
	// Clock and reset.
	input wire logic REF_CLK,
	input wire logic RST,
	// Monitored value and setpoint.
	input wire logic [limit_alarm_pkg::VAL_W-1:0] MEAS_VALUE,
	input wire logic [limit_alarm_pkg::VAL_W-1:0] SETPOINT,
	input wire logic SETPOINT_CHG,
	// Acknowledge sources.
	input wire logic ACK_KEY,
	input wire logic ACK_DIN,
	// Alarm outputs.
	output logic [limit_alarm_pkg::NUM_CH-1:0] ALARM_OUT,
	// AXI4-Lite write address.
	input wire logic AWVALID,
	output logic AWREADY,
	input wire logic [limit_alarm_pkg::ADDR_W-1:0] AWADDR,
	input wire logic [2:0] AWPROT,
	// AXI4-Lite write data.
	input wire logic WVALID,
	output logic WREADY,
	input wire logic [limit_alarm_pkg::DATA_W-1:0] WDATA,
	input wire logic [3:0] WSTRB,
	// AXI4-Lite write response.
	output logic BVALID,
	input wire logic BREADY,
	output logic [1:0] BRESP,
	// AXI4-Lite read address.
	input wire logic ARVALID,
	output logic ARREADY,
	input wire logic [limit_alarm_pkg::ADDR_W-1:0] ARADDR,
	input wire logic [2:0] ARPROT,
	// AXI4-Lite read data.
	output logic RVALID,
	input wire logic RREADY,
	output logic [limit_alarm_pkg::DATA_W-1:0] RDATA,
	output logic [1:0] RRESP
);
	import limit_alarm_pkg::*;

	// Merges a bus write into a word according to the byte strobes.
	function automatic logic [DATA_W-1:0] merge_f(input logic [DATA_W-1:0] old_v,
		input logic [DATA_W-1:0] new_v, input logic [3:0] strb);
		logic [DATA_W-1:0] res;
		res = old_v;
		for (int b = 0; b < 4; b++) begin
			if (strb[b]) begin
				res[b*8 +: 8] = new_v[b*8 +: 8];
			end
		end
		return res;
	endfunction : merge_f

	// True when the value lies beyond the limit of one channel.
	function automatic logic beyond_f(input logic [VAL_W-1:0] meas, input logic [VAL_W-1:0] sp,
		input logic [VAL_W-1:0] lim, input logic abs_mode, input logic above);
		logic signed [VAL_W:0] thr;
		logic signed [VAL_W:0] val;
		val = {meas[VAL_W-1], meas};
		if (abs_mode) begin
			thr = {lim[VAL_W-1], lim};
		end else begin
			thr = $signed({sp[VAL_W-1], sp}) + $signed({lim[VAL_W-1], lim});
		end
		return above ? (val > thr) : (val < thr);
	endfunction : beyond_f

	// Configuration registers.
	logic [CTRL_W-1:0] ctrl_q [NUM_CH];
	logic [VAL_W-1:0] limit_q [NUM_CH];
	logic [CNT_W-1:0] on_pre_q [NUM_CH];
	logic [CNT_W-1:0] off_pre_q [NUM_CH];
	logic [CNT_W-1:0] pulse_pre_q [NUM_CH];
	logic [CNT_W-1:0] tick_div_q;

	// Channel state.
	logic [NUM_CH-1:0] beyond_w;
	logic [NUM_CH-1:0] evt_w;
	logic [NUM_CH-1:0] armed_eff_w;
	logic [NUM_CH-1:0] out_pre_w;
	logic [NUM_CH-1:0] armed_q;
	logic [NUM_CH-1:0] dly_q;
	logic [NUM_CH-1:0] out_pre_q;
	logic [NUM_CH-1:0] alarm_q;
	logic [CNT_W-1:0] on_cnt_q [NUM_CH];
	logic [CNT_W-1:0] off_cnt_q [NUM_CH];
	logic [CNT_W-1:0] pulse_cnt_q [NUM_CH];

	// Time base and acknowledge path.
	logic [CNT_W-1:0] div_cnt_q;
	logic tick_w;
	logic ack_meta_q;
	logic ack_sync_q;
	logic ack_prev_q;
	logic ack_w;

	// Bus slave state.
	logic aw_held_q;
	logic w_held_q;
	logic [ADDR_W-1:0] aw_addr_q;
	logic [DATA_W-1:0] w_data_q;
	logic [3:0] w_strb_q;
	logic bvalid_q;
	logic [1:0] bresp_q;
	logic rvalid_q;
	logic [DATA_W-1:0] rdata_q;
	logic [1:0] rresp_q;
	logic wr_fire_w;
	logic [CH_IDX_W-1:0] wr_ch_w;
	logic [1:0] wr_sub_w;
	logic [CH_IDX_W-1:0] rd_ch_w;
	logic [1:0] rd_sub_w;

	always_ff @(posedge REF_CLK or posedge RST) begin
		if (RST) begin
			div_cnt_q <= '0;
		end else if (div_cnt_q == '0) begin
			div_cnt_q <= (tick_div_q == '0) ? '0 : tick_div_q - 1'b1;
		end else begin
			div_cnt_q <= div_cnt_q - 1'b1;
		end
	end
	assign tick_w = (div_cnt_q == '0);

	// Both sources are merged before the synchroniser.
	always_ff @(posedge REF_CLK or posedge RST) begin
		if (RST) begin
			ack_meta_q <= 1'b0;
			ack_sync_q <= 1'b0;
			ack_prev_q <= 1'b0;
		end else begin
			ack_meta_q <= ACK_KEY | ACK_DIN;
			ack_sync_q <= ack_meta_q;
			ack_prev_q <= ack_sync_q;
		end
	end
	assign ack_w = ack_sync_q & ~ack_prev_q;

	// Per-channel comparison, arming and the output before the lock.
	always_comb begin
		for (int i = 0; i < NUM_CH; i++) begin
			beyond_w[i] = beyond_f(MEAS_VALUE, SETPOINT, limit_q[i], ctrl_q[i][CTRL_ABS], ctrl_q[i][CTRL_ABOVE]);
			armed_eff_w[i] = armed_q[i] | ~ctrl_q[i][CTRL_SUPP];
			evt_w[i] = beyond_w[i] & armed_eff_w[i];
			out_pre_w[i] = dly_q[i] & ~(ctrl_q[i][CTRL_PULSE] & (pulse_cnt_q[i] == '0));
		end
	end

	// Arm on first entry to the valid range.
	always_ff @(posedge REF_CLK or posedge RST) begin
		if (RST) begin
			armed_q <= '0;
		end else begin
			for (int i = 0; i < NUM_CH; i++) begin
				if (SETPOINT_CHG) begin
					armed_q[i] <= 1'b0;
				end else if (!beyond_w[i]) begin
					armed_q[i] <= 1'b1;
				end
			end
		end
	end

	// Switch-on countdown reloads whenever the event is absent.
	always_ff @(posedge REF_CLK or posedge RST) begin
		if (RST) begin
			for (int i = 0; i < NUM_CH; i++) begin
				on_cnt_q[i] <= '0;
				off_cnt_q[i] <= '0;
			end
		end else begin
			for (int i = 0; i < NUM_CH; i++) begin
				if (!evt_w[i]) begin
					on_cnt_q[i] <= on_pre_q[i];
				end else if (tick_w && on_cnt_q[i] != '0) begin
					on_cnt_q[i] <= on_cnt_q[i] - 1'b1;
				end
				// Switch-off countdown reloads while the event is present.
				if (evt_w[i]) begin
					off_cnt_q[i] <= off_pre_q[i];
				end else if (tick_w && off_cnt_q[i] != '0) begin
					off_cnt_q[i] <= off_cnt_q[i] - 1'b1;
				end
			end
		end
	end

	// Delayed event flag.
	always_ff @(posedge REF_CLK or posedge RST) begin
		if (RST) begin
			dly_q <= '0;
		end else begin
			for (int i = 0; i < NUM_CH; i++) begin
				// Hold until countdown ends; then pass the event on.
				if (evt_w[i] && on_cnt_q[i] == '0) begin
					dly_q[i] <= 1'b1;
				// Pulse mode drops the switch-off delay.
				end else if (!evt_w[i] && (ctrl_q[i][CTRL_PULSE] || off_cnt_q[i] == '0)) begin
					dly_q[i] <= 1'b0;
				end
			end
		end
	end

	// Pulse timer reloads in the valid range, runs while output is on.
	always_ff @(posedge REF_CLK or posedge RST) begin
		if (RST) begin
			for (int i = 0; i < NUM_CH; i++) begin
				pulse_cnt_q[i] <= '0;
			end
		end else begin
			for (int i = 0; i < NUM_CH; i++) begin
				if (!evt_w[i]) begin
					pulse_cnt_q[i] <= pulse_pre_q[i];
				end else if (dly_q[i] && tick_w && pulse_cnt_q[i] != '0) begin
					pulse_cnt_q[i] <= pulse_cnt_q[i] - 1'b1;
				end
			end
		end
	end

	// Lock stage; latched modes set on the rising edge of the pre-lock output.
	always_ff @(posedge REF_CLK or posedge RST) begin
		if (RST) begin
			out_pre_q <= '0;
			alarm_q <= '0;
		end else begin
			out_pre_q <= out_pre_w;
			for (int i = 0; i < NUM_CH; i++) begin
				case (lock_mode_t'(ctrl_q[i][CTRL_LOCK_LSB +: 2]))
					LOCK_NORMAL: begin
						if (out_pre_w[i] && !out_pre_q[i]) begin
							alarm_q[i] <= 1'b1;
						// Acknowledge only once event is gone.
						end else if (ack_w && !beyond_w[i]) begin
							alarm_q[i] <= 1'b0;
						end
					end
					LOCK_ALWAYS: begin
						if (out_pre_w[i] && !out_pre_q[i]) begin
							alarm_q[i] <= 1'b1;
						end else if (ack_w) begin
							alarm_q[i] <= 1'b0;
						end
					end
					default: begin
						alarm_q[i] <= out_pre_w[i];
					end
				endcase
			end
		end
	end
	assign ALARM_OUT = alarm_q;

	// Write channel: address and data are taken independently and held.
	assign AWREADY = ~aw_held_q;
	assign WREADY = ~w_held_q;
	assign wr_fire_w = aw_held_q & w_held_q & ~bvalid_q;
	assign wr_ch_w = aw_addr_q[CH_LSB +: CH_IDX_W];
	assign wr_sub_w = aw_addr_q[3:2];
	always_ff @(posedge REF_CLK or posedge RST) begin
		if (RST) begin
			aw_held_q <= 1'b0;
			w_held_q <= 1'b0;
			aw_addr_q <= '0;
			w_data_q <= '0;
			w_strb_q <= '0;
			bvalid_q <= 1'b0;
			bresp_q <= RESP_OKAY;
		end else begin
			if (AWVALID && !aw_held_q) begin
				aw_held_q <= 1'b1;
				aw_addr_q <= AWADDR;
			end else if (wr_fire_w) begin
				aw_held_q <= 1'b0;
			end
			if (WVALID && !w_held_q) begin
				w_held_q <= 1'b1;
				w_data_q <= WDATA;
				w_strb_q <= WSTRB;
			end else if (wr_fire_w) begin
				w_held_q <= 1'b0;
			end
			if (wr_fire_w) begin
				bvalid_q <= 1'b1;
				bresp_q <= (!aw_addr_q[GLOBAL_BIT] || aw_addr_q == ADDR_TICK_DIV) ? RESP_OKAY : RESP_SLVERR;
			end else if (BREADY) begin
				bvalid_q <= 1'b0;
			end
		end
	end
	assign BVALID = bvalid_q;
	assign BRESP = bresp_q;

	// Register writes.
	always_ff @(posedge REF_CLK or posedge RST) begin
		if (RST) begin
			tick_div_q <= CNT_W'(TICK_DIV_DEFAULT);
			for (int i = 0; i < NUM_CH; i++) begin
				ctrl_q[i] <= CTRL_RST;
				limit_q[i] <= '0;
				on_pre_q[i] <= '0;
				off_pre_q[i] <= '0;
				pulse_pre_q[i] <= '0;
			end
		end else if (wr_fire_w) begin
			if (aw_addr_q == ADDR_TICK_DIV) begin
				tick_div_q <= CNT_W'(merge_f(DATA_W'(tick_div_q), w_data_q, w_strb_q));
			end else if (!aw_addr_q[GLOBAL_BIT]) begin
				case (wr_sub_w)
					SUB_CTRL: begin
						ctrl_q[wr_ch_w] <= CTRL_W'(merge_f(DATA_W'(ctrl_q[wr_ch_w]), w_data_q, w_strb_q));
					end
					SUB_LIMIT: begin
						limit_q[wr_ch_w] <= VAL_W'(merge_f(DATA_W'(limit_q[wr_ch_w]), w_data_q, w_strb_q));
					end
					SUB_DELAY: begin
						on_pre_q[wr_ch_w] <= CNT_W'(merge_f({off_pre_q[wr_ch_w], on_pre_q[wr_ch_w]}, w_data_q,
							w_strb_q));
						off_pre_q[wr_ch_w] <= CNT_W'(merge_f({off_pre_q[wr_ch_w], on_pre_q[wr_ch_w]}, w_data_q,
							w_strb_q) >> DLY_OFF_LSB);
					end
					default: begin
						pulse_pre_q[wr_ch_w] <= CNT_W'(merge_f(DATA_W'(pulse_pre_q[wr_ch_w]), w_data_q,
							w_strb_q));
					end
				endcase
			end
		end
	end

	// Read channel: one read in flight, data registered.
	assign ARREADY = ~rvalid_q;
	assign rd_ch_w = ARADDR[CH_LSB +: CH_IDX_W];
	assign rd_sub_w = ARADDR[3:2];
	always_ff @(posedge REF_CLK or posedge RST) begin
		if (RST) begin
			rvalid_q <= 1'b0;
			rdata_q <= '0;
			rresp_q <= RESP_OKAY;
		end else if (ARVALID && !rvalid_q) begin
			rvalid_q <= 1'b1;
			rresp_q <= RESP_OKAY;
			rdata_q <= '0;
			if (!ARADDR[GLOBAL_BIT]) begin
				case (rd_sub_w)
					SUB_CTRL: rdata_q <= DATA_W'(ctrl_q[rd_ch_w]);
					SUB_LIMIT: rdata_q <= DATA_W'(limit_q[rd_ch_w]);
					SUB_DELAY: rdata_q <= {off_pre_q[rd_ch_w], on_pre_q[rd_ch_w]};
					default: rdata_q <= DATA_W'(pulse_pre_q[rd_ch_w]);
				endcase
			end else if (ARADDR == ADDR_TICK_DIV) begin
				rdata_q <= DATA_W'(tick_div_q);
			end else if (ARADDR == ADDR_STATUS) begin
				rdata_q[ST_OUT_LSB +: NUM_CH] <= alarm_q;
				rdata_q[ST_ARM_LSB +: NUM_CH] <= armed_eff_w;
				rdata_q[ST_BEYOND_LSB +: NUM_CH] <= beyond_w;
			end else begin
				rresp_q <= RESP_SLVERR;
			end
		end else if (RREADY) begin
			rvalid_q <= 1'b0;
		end
	end
	assign RVALID = rvalid_q;
	assign RDATA = rdata_q;
	assign RRESP = rresp_q;

endmodule : limit_alarm_monitor

// file: rtl/limit_alarm_pkg.sv
package limit_alarm_pkg;

	// Channel count and data widths.
	localparam int NUM_CH = 8;
	localparam int VAL_W = 16;
	localparam int CNT_W = 16;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;

	// Time base: one tick per millisecond at a 40 ns clock.
	localparam int CLK_PERIOD_NS = 40;
	localparam int TICK_PERIOD_NS = 1000000;
	localparam int TICK_CYCLES = TICK_PERIOD_NS / CLK_PERIOD_NS;

	// Per-channel register block: channel index in address bits 6:4.
	localparam int CH_LSB = 4;
	localparam int CH_IDX_W = 3;
	localparam logic [1:0] SUB_CTRL = 2'h0;
	localparam logic [1:0] SUB_LIMIT = 2'h1;
	localparam logic [1:0] SUB_DELAY = 2'h2;
	localparam logic [1:0] SUB_PULSE = 2'h3;
	localparam int GLOBAL_BIT = 7;

	// Global registers.
	localparam logic [ADDR_W-1:0] ADDR_TICK_DIV = 8'h80;
	localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h84;

	// Channel control field layout.
	localparam int CTRL_W = 6;
	localparam int CTRL_ABS = 0;
	localparam int CTRL_ABOVE = 1;
	localparam int CTRL_PULSE = 2;
	localparam int CTRL_SUPP = 3;
	localparam int CTRL_LOCK_LSB = 4;
	localparam logic [CTRL_W-1:0] CTRL_RST = 6'h02;

	// Delay register layout: switch-on delay low half, switch-off delay high half.
	localparam int DLY_OFF_LSB = 16;

	// Status register layout.
	localparam int ST_OUT_LSB = 0;
	localparam int ST_ARM_LSB = 8;
	localparam int ST_BEYOND_LSB = 16;

	// Bus responses.
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// Lock modes as held in the control field.
	typedef enum logic [1:0] {
		LOCK_OFF,
		LOCK_NORMAL,
		LOCK_ALWAYS
	} lock_mode_t;

endpackage : limit_alarm_pkg

// file: test/alarm_source_model.sv
module alarm_source_model (
	// Clock.
	input wire logic clk,
	// Requests from the bench.
	input wire logic [limit_alarm_pkg::VAL_W-1:0] value_req,
	input wire logic key_req,
	input wire logic din_req,
	// Pins toward the monitor.
	output logic [limit_alarm_pkg::VAL_W-1:0] meas,
	output logic ack_key,
	output logic ack_din
);
	timeunit 1ns;
	timeprecision 1ps;
	import limit_alarm_pkg::*;
	int key_n;
	int din_n;

	// Pins start idle.
	initial begin
		meas = '0;
		ack_key = 1'b0;
		ack_din = 1'b0;
		key_n = 0;
		din_n = 0;
	end

	// The converter hands over a requested sample one clock later.
	always @(posedge clk) begin
		meas <= value_req;
	end

	// both acknowledge sources
	// A key press or a contact closure is held for a few clocks, then released.
	always @(posedge clk) begin
		key_n <= key_req ? 4 : (key_n > 0 ? key_n - 1 : 0);
		din_n <= din_req ? 4 : (din_n > 0 ? din_n - 1 : 0);
		ack_key <= key_req || key_n > 1;
		ack_din <= din_req || din_n > 1;
	end
endmodule : alarm_source_model

// file: test/limit_alarm_monitor_asserts.sv
module limit_alarm_monitor_asserts (
	// Clock and reset.
	input wire logic REF_CLK,
	input wire logic RST,
	// Alarm outputs.
	input wire logic [limit_alarm_pkg::NUM_CH-1:0] ALARM_OUT,
	// Register bus.
	input wire logic AWVALID,
	input wire logic AWREADY,
	input wire logic [limit_alarm_pkg::ADDR_W-1:0] AWADDR,
	input wire logic WVALID,
	input wire logic WREADY,
	input wire logic BVALID,
	input wire logic [1:0] BRESP,
	input wire logic ARVALID,
	input wire logic ARREADY,
	input wire logic [limit_alarm_pkg::ADDR_W-1:0] ARADDR,
	input wire logic RVALID,
	input wire logic RREADY,
	input wire logic [limit_alarm_pkg::DATA_W-1:0] RDATA,
	input wire logic [1:0] RRESP
);
	timeunit 1ns;
	timeprecision 1ps;
	import limit_alarm_pkg::*;
	default clocking cb @(posedge REF_CLK);
	endclocking
	default disable iff (RST);

	// Reset leaves every output inactive, and the bus answers follow their requests.
	a_reset_quiet: assert property ($fell(RST) |-> ALARM_OUT == '0)
		else $error("alarm active after reset");
	a_write_answer: assert property (AWVALID && AWREADY && WVALID && WREADY |-> ##2 BVALID)
		else $error("write response missing");
	a_write_unmapped: assert property (AWVALID && AWREADY && WVALID && WREADY && AWADDR >= 8'h84
		|-> ##2 BRESP == RESP_SLVERR) else $error("unmapped write accepted");
	a_read_answer: assert property (ARVALID && ARREADY |=> RVALID)
		else $error("read data missing");
	a_read_refused: assert property (RVALID |-> !ARREADY)
		else $error("read taken while busy");
	a_read_hold: assert property (RVALID && !RREADY |=> RVALID && $stable(RDATA) && $stable(RRESP))
		else $error("read data dropped early");
	a_read_unmapped: assert property (ARVALID && ARREADY && ARADDR >= 8'h88
		|=> RRESP == RESP_SLVERR && RDATA == '0) else $error("unmapped read accepted");
	a_status_out: assert property (ARVALID && ARREADY && ARADDR == ADDR_STATUS
		|=> RDATA[7:0] == $past(ALARM_OUT) && RDATA[31:24] == '0) else $error("status disagrees");
endmodule : limit_alarm_monitor_asserts

bind limit_alarm_monitor limit_alarm_monitor_asserts chk_u (.REF_CLK(REF_CLK), .RST(RST),
	.ALARM_OUT(ALARM_OUT), .AWVALID(AWVALID), .AWREADY(AWREADY), .AWADDR(AWADDR),
	.WVALID(WVALID), .WREADY(WREADY), .BVALID(BVALID), .BRESP(BRESP), .ARVALID(ARVALID),
	.ARREADY(ARREADY), .ARADDR(ARADDR), .RVALID(RVALID), .RREADY(RREADY), .RDATA(RDATA), .RRESP(RRESP));

// file: test/limit_alarm_monitor_tb_top.sv
module limit_alarm_monitor_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import limit_alarm_pkg::*;
	logic REF_CLK, RST, SETPOINT_CHG, ACK_KEY, ACK_DIN, key_req, din_req;
	logic AWVALID, AWREADY, WVALID, WREADY, BVALID, BREADY, ARVALID, ARREADY, RVALID, RREADY;
	logic [VAL_W-1:0] MEAS_VALUE, SETPOINT, val_req;
	logic [NUM_CH-1:0] ALARM_OUT, e;
	logic [ADDR_W-1:0] AWADDR, ARADDR;
	logic [DATA_W-1:0] WDATA, RDATA, rd_q;
	logic [1:0] BRESP, RRESP;
	int mismatches, n_tests, sp, v;
	int lim[NUM_CH];
	logic [CTRL_W-1:0] cfg[NUM_CH];

	limit_alarm_monitor #(.TICK_DIV_DEFAULT(4)) dut_u (.REF_CLK(REF_CLK), .RST(RST),
		.MEAS_VALUE(MEAS_VALUE), .SETPOINT(SETPOINT), .SETPOINT_CHG(SETPOINT_CHG), .ACK_KEY(ACK_KEY),
		.ACK_DIN(ACK_DIN), .ALARM_OUT(ALARM_OUT), .AWVALID(AWVALID), .AWREADY(AWREADY), .AWADDR(AWADDR),
		.AWPROT(3'h0), .WVALID(WVALID), .WREADY(WREADY), .WDATA(WDATA), .WSTRB(4'hf), .BVALID(BVALID),
		.BREADY(BREADY), .BRESP(BRESP), .ARVALID(ARVALID), .ARREADY(ARREADY), .ARADDR(ARADDR),
		.ARPROT(3'h0), .RVALID(RVALID), .RREADY(RREADY), .RDATA(RDATA), .RRESP(RRESP));
	alarm_source_model src_u (.clk(REF_CLK), .value_req(val_req), .key_req(key_req), .din_req(din_req),
		.meas(MEAS_VALUE), .ack_key(ACK_KEY), .ack_din(ACK_DIN));

	// Free-running clock.
	initial begin
		REF_CLK = 1'b0;
		forever #20 REF_CLK = ~REF_CLK;
	end

	task automatic final_report();
		$display("mismatches=%0d n_tests=%0d", mismatches, n_tests);
		if (mismatches == 0 && n_tests > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask : final_report

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			mismatches++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task automatic cyc(input int n);
		repeat (n) @(posedge REF_CLK);
	endtask : cyc

	task automatic ob(input int ch, input logic x);
		chk(32'(ALARM_OUT[ch]), 32'(x));
	endtask : ob

	// Write both channels together, release each when taken, then wait for the response.
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		logic aw, w;
		aw = 1'b0;
		w = 1'b0;
		AWADDR <= a;
		WDATA <= d;
		AWVALID <= 1'b1;
		WVALID <= 1'b1;
		BREADY <= 1'b1;
		while (!(aw && w)) begin
			@(posedge REF_CLK);
			if (AWVALID && AWREADY) begin
				aw = 1'b1;
				AWVALID <= 1'b0;
			end
			if (WVALID && WREADY) begin
				w = 1'b1;
				WVALID <= 1'b0;
			end
		end
		while (BVALID !== 1'b1) @(posedge REF_CLK);
		BREADY <= 1'b0;
		chk(32'(BRESP), 32'(er));
		// Let one edge pass so a following call never re-raises a ready in this time step.
		@(posedge REF_CLK);
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [1:0] er);
		ARADDR <= a;
		ARVALID <= 1'b1;
		RREADY <= 1'b1;
		do @(posedge REF_CLK); while (ARREADY !== 1'b1);
		ARVALID <= 1'b0;
		while (RVALID !== 1'b1) @(posedge REF_CLK);
		rd_q = RDATA;
		RREADY <= 1'b0;
		chk(32'(RRESP), 32'(er));
		@(posedge REF_CLK);
	endtask : rd

	// Configure one channel and remember its settings for the model.
	task automatic setch(input int ch, input logic [5:0] c, input int l, input logic [31:0] dl, input int p);
		cfg[ch] = c;
		lim[ch] = l;
		wr(8'(ch * 16), 32'(c), RESP_OKAY);
		wr(8'(ch * 16 + 4), 32'(l), RESP_OKAY);
		wr(8'(ch * 16 + 8), dl, RESP_OKAY);
		wr(8'(ch * 16 + 12), 32'(p), RESP_OKAY);
	endtask : setch

	task automatic setv(input int x);
		val_req <= 16'(x);
		cyc(1);
	endtask : setv

	task automatic pulse_ack(input logic din);
		if (din) din_req <= 1'b1;
		else key_req <= 1'b1;
		cyc(1);
		din_req <= 1'b0;
		key_req <= 1'b0;
	endtask : pulse_ack

	// Model of the limit compare; threshold is relative or absolute.
	function automatic logic beyond_m(input int ch, input int x, input int s);
		int th;
		th = cfg[ch][CTRL_ABS] ? lim[ch] : s + lim[ch];
		return cfg[ch][CTRL_ABOVE] ? (x > th) : (x < th);
	endfunction : beyond_m

	// Watchdog against a hung handshake.
	initial begin
		cyc(20000);
		mismatches++;
		final_report();
	end

	// Main sequence.
	initial begin
		RST = 1'b1;
		{SETPOINT_CHG, key_req, din_req, AWVALID, WVALID, BREADY, ARVALID, RREADY} = '0;
		{SETPOINT, val_req, AWADDR, ARADDR, WDATA} = '0;
		mismatches = 0;
		n_tests = 0;
		void'($urandom(16037));
		cyc(12);
		RST <= 1'b0;
		cyc(2);
		rd(8'h70, RESP_OKAY);
		chk(rd_q, 32'(CTRL_RST));
		rd(ADDR_TICK_DIV, RESP_OKAY);
		chk(rd_q, 32'h4);
		wr(ADDR_TICK_DIV, 32'h4, RESP_OKAY);
		wr(8'h90, 32'h1, RESP_SLVERR);
		wr(ADDR_STATUS, 32'hff, RESP_SLVERR);
		rd(8'ha0, RESP_SLVERR);
		chk(rd_q, 32'h0);
		for (int ch = 0; ch < NUM_CH; ch++) setch(ch, 6'(ch % 4), 2 * int'($urandom % 1000) - 1001, 0, 0);
		// Odd limits against even values keep the compare away from equality.
		repeat (12) begin
			sp = 2 * int'($urandom % 1001) - 1000;
			v = 2 * int'($urandom % 4001) - 4000;
			SETPOINT <= 16'(sp);
			setv(v);
			cyc(6);
			for (int ch = 0; ch < NUM_CH; ch++) e[ch] = beyond_m(ch, v, sp);
			rd(ADDR_STATUS, RESP_OKAY);
			chk(32'(rd_q[23:16]), 32'(e));
			chk(32'(ALARM_OUT), 32'(e));
		end
		setv(0);
		setch(0, 6'h03, 101, {16'd12, 16'd12}, 0);
		setch(1, 6'h07, 101, {16'd12, 16'd0}, 10);
		setch(2, 6'h0b, 101, 0, 0);
		setch(3, 6'h13, 101, 0, 0);
		setch(4, 6'h23, 101, 0, 0);
		cyc(8);
		// Rise, a short dip, then a second rise.
		setv(200);
		cyc(19);
		ob(0, 1'b0);
		ob(1, 1'b1);
		ob(3, 1'b1);
		setv(0);
		cyc(5);
		ob(1, 1'b0);
		cyc(4);
		setv(200);
		cyc(34);
		ob(1, 1'b1);
		cyc(9);
		ob(0, 1'b0);
		pulse_ack(1'b0);
		cyc(11);
		ob(3, 1'b1);
		ob(4, 1'b0);
		cyc(24);
		ob(0, 1'b1);
		ob(1, 1'b0);
		setv(0);
		cyc(29);
		ob(0, 1'b1);
		cyc(50);
		ob(0, 1'b0);
		ob(3, 1'b1);
		pulse_ack(1'b1);
		cyc(11);
		ob(3, 1'b0);
		// Suppression: a setpoint change on the clock where the value starts to rise disarms the channel.
		SETPOINT_CHG <= 1'b1;
		setv(200);
		SETPOINT_CHG <= 1'b0;
		cyc(11);
		ob(2, 1'b0);
		setv(0);
		cyc(5);
		setv(200);
		cyc(6);
		ob(2, 1'b1);
		final_report();
	end
endmodule : limit_alarm_monitor_tb_top
